// File: src/ppfh_pkg.sv
package ppfh_pkg;

  // Frame and code values.
  localparam int        FRAME_LEN       = 40;
  localparam logic [5:0] LAST_IDX       = 6'h27;
  localparam logic [7:0] CR_CODE        = 8'h0d;
  localparam logic [7:0] BLANK_CODE     = 8'h20;
  localparam logic [7:0] EOL_DEFAULT    = 8'h9b;

  // Completion status values.
  localparam logic [7:0] ST_OK          = 8'h80;
  localparam logic [7:0] ST_BAD_CMD     = 8'h81;
  localparam logic [7:0] ST_FRAME_ERR   = 8'h82;
  localparam logic [7:0] ST_TIMEOUT     = 8'h84;

  // Host command codes.
  localparam logic [1:0] CMD_WRITE      = 2'h1;
  localparam logic [1:0] CMD_STATUS     = 2'h2;

  // Timing.
  localparam int        CLK_HZ          = 40000000;
  localparam int        ACK_LIMIT_S     = 4;
  localparam int        ACK_LIMIT_CYC   = ACK_LIMIT_S * CLK_HZ;

  typedef enum logic [2:0] {
    PPFH_IDLE,
    PPFH_RECV,
    PPFH_STROBE,
    PPFH_RELEASE,
    PPFH_ANSWER
  } ppfh_state_t;

endpackage : ppfh_pkg

// File: src/ppfh_frame_handler.sv
// Operation
// - Answer printer commands only with printer attached.
// - Accept 40-byte frame, forward bytes in order.
// - Drop characters following a line terminator.
// - Forward line terminator as carriage return 13.
// - Other bytes pass unchanged, no line feed.
// - Consecutive terminators alternate carriage return, blank.
// - Frame without terminator forwarded whole, nothing added.
// - Status answered only when attached and powered.
// - Status 128 success, 129 bad command.
// - Status 130 after errored data frame.
// - Status 132 after 4 s frame print timeout.
module ppfh_frame_handler #(
  parameter int         TIMEOUT_CYCLES       = ppfh_pkg::ACK_LIMIT_CYC,
  parameter logic [7:0] LINE_TERMINATOR_CODE = ppfh_pkg::EOL_DEFAULT
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Host commands
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_code,
  output logic            cmd_ready,
  // Host frame bytes
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  input  wire logic       byte_err,
  output logic            byte_ready,
  // Host answer
  output logic            resp_valid,
  output logic [7:0]      resp_status,
  // Printer port pins
  input  wire logic       printer_present,
  input  wire logic       printer_power,
  input  wire logic       prn_ack,
  output logic            prn_strobe,
  output logic [7:0]      prn_data
);

  ppfh_pkg::ppfh_state_t state, next_state;
  logic [7:0]  frame_mem [ppfh_pkg::FRAME_LEN];
  logic [2:0]  sync1, sync2;
  logic [5:0]  rcv_idx, next_rcv_idx;
  logic [5:0]  send_idx, next_send_idx;
  logic [5:0]  stop_idx, next_stop_idx;
  logic        eol_seen, next_eol_seen;
  logic        rcv_err, next_rcv_err;
  logic        eol_run, next_eol_run;
  logic [27:0] timer, next_timer;
  logic [7:0]  next_status;
  logic        next_resp_valid;
  logic        next_strobe;
  logic [7:0]  next_prn_data;
  logic        attached, powered, ack_s;
  logic        byte_take, timed_out;
  logic [5:0]  load_idx;
  logic [7:0]  load_char;

  // Pins are asynchronous to sys_clk; only sync2 is read by logic.
  always_ff @(posedge sys_clk) begin
    sync1 <= {printer_present, printer_power, prn_ack};
    sync2 <= sync1;
  end

  assign attached   = sync2[2];
  assign powered    = sync2[1];
  assign ack_s      = sync2[0];
  assign cmd_ready  = (state == ppfh_pkg::PPFH_IDLE);
  assign byte_ready = (state == ppfh_pkg::PPFH_RECV);
  assign byte_take  = byte_valid && byte_ready;
  assign timed_out  = (timer >= 28'(TIMEOUT_CYCLES - 1));
  assign load_idx   = (state == ppfh_pkg::PPFH_RECV) ? 6'h00 : send_idx + 6'h01;
  assign load_char  = frame_mem[load_idx];

  always_ff @(posedge sys_clk) begin
    if (byte_take) begin
      frame_mem[rcv_idx] <= byte_data;
    end
  end

  always_comb begin
    next_state      = state;
    next_rcv_idx    = rcv_idx;
    next_send_idx   = send_idx;
    next_stop_idx   = stop_idx;
    next_eol_seen   = eol_seen;
    next_rcv_err    = rcv_err;
    next_eol_run    = eol_run;
    next_timer      = timer;
    next_status     = resp_status;
    next_resp_valid = 1'b0;
    next_strobe     = prn_strobe;
    next_prn_data   = prn_data;
    case (state)
      ppfh_pkg::PPFH_IDLE: begin
        if (cmd_valid && attached) begin
          if (cmd_code == ppfh_pkg::CMD_WRITE) begin
            next_state    = ppfh_pkg::PPFH_RECV;
            next_rcv_idx  = 6'h00;
            next_eol_seen = 1'b0;
            next_rcv_err  = 1'b0;
            next_stop_idx = ppfh_pkg::LAST_IDX;
          end else if (cmd_code == ppfh_pkg::CMD_STATUS) begin
            if (powered) begin
              next_state = ppfh_pkg::PPFH_ANSWER;
            end
          end else begin
            next_status = ppfh_pkg::ST_BAD_CMD;
            next_state  = ppfh_pkg::PPFH_ANSWER;
          end
        end
      end
      ppfh_pkg::PPFH_RECV: begin
        if (byte_take) begin
          next_rcv_idx = rcv_idx + 6'h01;
          next_rcv_err = rcv_err | byte_err;
          if (byte_data == LINE_TERMINATOR_CODE && !eol_seen) begin
            next_eol_seen = 1'b1;
            next_stop_idx = rcv_idx;
          end
          if (rcv_idx == ppfh_pkg::LAST_IDX) begin
            if (rcv_err || byte_err) begin
              next_status = ppfh_pkg::ST_FRAME_ERR;
              next_state  = ppfh_pkg::PPFH_ANSWER;
            end else begin
              next_state    = ppfh_pkg::PPFH_STROBE;
              next_send_idx = 6'h00;
              next_timer    = '0;
              next_strobe   = 1'b1;
            end
          end
        end
      end
      ppfh_pkg::PPFH_STROBE: begin
        next_timer = timer + 28'h1;
        if (ack_s) begin
          next_strobe = 1'b0;
          next_state  = ppfh_pkg::PPFH_RELEASE;
        end
      end
      ppfh_pkg::PPFH_RELEASE: begin
        next_timer = timer + 28'h1;
        if (!ack_s) begin
          if (send_idx == stop_idx) begin
            next_status = ppfh_pkg::ST_OK;
            next_state  = ppfh_pkg::PPFH_ANSWER;
          end else begin
            next_send_idx = send_idx + 6'h01;
            next_strobe   = 1'b1;
            next_state    = ppfh_pkg::PPFH_STROBE;
          end
        end
      end
      ppfh_pkg::PPFH_ANSWER: begin
        next_resp_valid = 1'b1;
        next_state      = ppfh_pkg::PPFH_IDLE;
      end
      default: begin
        next_state = ppfh_pkg::PPFH_IDLE;
      end
    endcase
    // Character is latched as the strobe goes up, so data is stable for the whole strobe.
    if (next_strobe && !prn_strobe) begin
      if (load_char == LINE_TERMINATOR_CODE) begin
        next_prn_data = eol_run ? ppfh_pkg::BLANK_CODE : ppfh_pkg::CR_CODE;
        next_eol_run  = !eol_run;
      end else begin
        next_prn_data = load_char;
        next_eol_run  = 1'b0;
      end
    end
    if ((state == ppfh_pkg::PPFH_STROBE || state == ppfh_pkg::PPFH_RELEASE) && timed_out) begin
      next_status   = ppfh_pkg::ST_TIMEOUT;
      next_strobe   = 1'b0;
      next_prn_data = prn_data;
      next_eol_run  = eol_run;
      next_state    = ppfh_pkg::PPFH_ANSWER;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state       <= ppfh_pkg::PPFH_IDLE;
      rcv_idx     <= 6'h00;
      send_idx    <= 6'h00;
      stop_idx    <= ppfh_pkg::LAST_IDX;
      eol_seen    <= 1'b0;
      rcv_err     <= 1'b0;
      eol_run     <= 1'b0;
      timer       <= 28'h0;
      resp_status <= ppfh_pkg::ST_OK;
      resp_valid  <= 1'b0;
      prn_strobe  <= 1'b0;
      prn_data    <= 8'h00;
    end else begin
      state       <= next_state;
      rcv_idx     <= next_rcv_idx;
      send_idx    <= next_send_idx;
      stop_idx    <= next_stop_idx;
      eol_seen    <= next_eol_seen;
      rcv_err     <= next_rcv_err;
      eol_run     <= next_eol_run;
      timer       <= next_timer;
      resp_status <= next_status;
      resp_valid  <= next_resp_valid;
      prn_strobe  <= next_strobe;
      prn_data    <= next_prn_data;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_cmd_seen_offline;
    cmd_valid && !attached && state == ppfh_pkg::PPFH_IDLE;
  endsequence
  property p_silent;
    s_cmd_seen_offline |=> state == ppfh_pkg::PPFH_IDLE ##1 !resp_valid;
  endproperty
  a_silent: assert property (p_silent) else $error("Answered a command with no printer.");

  property p_trim;
    $rose(prn_strobe) |-> send_idx <= stop_idx;
  endproperty
  a_trim: assert property (p_trim) else $error("Character after terminator forwarded.");

  property p_ack_first;
    prn_strobe && !ack_s && !timed_out |=> prn_strobe && $stable(prn_data);
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("Strobe dropped before acknowledge.");

  property p_cr;
    $rose(prn_strobe) && frame_mem[send_idx] == LINE_TERMINATOR_CODE && !$past(eol_run)
      |-> prn_data == ppfh_pkg::CR_CODE;
  endproperty
  a_cr: assert property (p_cr) else $error("Terminator not sent as carriage return.");

  property p_blank;
    $rose(prn_strobe) && frame_mem[send_idx] == LINE_TERMINATOR_CODE && $past(eol_run)
      |-> prn_data == ppfh_pkg::BLANK_CODE;
  endproperty
  a_blank: assert property (p_blank) else $error("Repeated terminator not sent as blank.");

  property p_pass;
    $rose(prn_strobe) && frame_mem[send_idx] != LINE_TERMINATOR_CODE |-> prn_data == frame_mem[send_idx];
  endproperty
  a_pass: assert property (p_pass) else $error("Ordinary byte altered.");

  property p_full_frame;
    byte_take && rcv_idx == ppfh_pkg::LAST_IDX && !eol_seen && byte_data != LINE_TERMINATOR_CODE
      |=> stop_idx == ppfh_pkg::LAST_IDX;
  endproperty
  a_full_frame: assert property (p_full_frame) else $error("Unterminated frame shortened.");

  property p_status_answer;
    cmd_valid && cmd_ready && attached && powered && cmd_code == ppfh_pkg::CMD_STATUS |-> ##2 resp_valid;
  endproperty
  a_status_answer: assert property (p_status_answer) else $error("Status request unanswered.");

  property p_bad_cmd;
    cmd_valid && cmd_ready && attached && cmd_code != ppfh_pkg::CMD_STATUS && cmd_code != ppfh_pkg::CMD_WRITE
      |-> ##2 resp_valid && resp_status == ppfh_pkg::ST_BAD_CMD;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("Bad command not reported as 129.");

  property p_frame_err;
    byte_take && (byte_err || rcv_err) && rcv_idx == ppfh_pkg::LAST_IDX
      |-> ##2 resp_valid && resp_status == ppfh_pkg::ST_FRAME_ERR;
  endproperty
  a_frame_err: assert property (p_frame_err) else $error("Errored frame not reported as 130.");

  property p_timeout;
    (state == ppfh_pkg::PPFH_STROBE || state == ppfh_pkg::PPFH_RELEASE) && timed_out
      |=> !prn_strobe ##1 resp_valid && resp_status == ppfh_pkg::ST_TIMEOUT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Timeout not reported as 132.");

endmodule : ppfh_frame_handler

// File: dv/ppfh_printer_model.sv
module ppfh_printer_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Printer pins
  input  wire logic       prn_strobe,
  input  wire logic [7:0] prn_data,
  output logic            prn_ack,
  // Behaviour control and observation
  input  wire logic       stall,
  input  wire logic [3:0] delay,
  output logic            seen,
  output logic [7:0]      seen_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  always_ff @(posedge sys_clk) begin
    seen <= 1'b0;
    if (sys_rst || !prn_strobe) begin
      prn_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (!prn_ack && !stall) begin
      if (wait_cnt == delay) begin
        prn_ack   <= 1'b1;
        seen      <= 1'b1;
        seen_data <= prn_data;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : ppfh_printer_model

// File: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         TMO  = 1000;
  localparam logic [7:0] TERM = ppfh_pkg::EOL_DEFAULT;
  logic       sys_clk = 1'b0, sys_rst = 1'b1;
  logic       cmd_valid = 1'b0, byte_valid = 1'b0, byte_err = 1'b0;
  logic [1:0] cmd_code = 2'h0;
  logic [7:0] byte_data = 8'h00;
  logic       printer_present = 1'b1, printer_power = 1'b1, stall = 1'b0;
  logic [3:0] delay = 4'h1;
  logic       cmd_ready, byte_ready, resp_valid, prn_ack, prn_strobe, seen;
  logic [7:0] resp_status, prn_data, seen_data;
  logic [7:0] fr [40];
  logic [7:0] got [$], exp_q [$];
  int         num_errors = 0, checked = 0;

  ppfh_frame_handler #(.TIMEOUT_CYCLES(TMO)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_err(byte_err), .byte_ready(byte_ready), .resp_valid(resp_valid),
    .resp_status(resp_status), .printer_present(printer_present), .printer_power(printer_power),
    .prn_ack(prn_ack), .prn_strobe(prn_strobe), .prn_data(prn_data));
  ppfh_printer_model prn_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .prn_strobe(prn_strobe),
    .prn_data(prn_data), .prn_ack(prn_ack), .stall(stall), .delay(delay), .seen(seen),
    .seen_data(seen_data));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (seen === 1'b1) got.push_back(seen_data);
  end

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cmd(input logic [1:0] code);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask : cmd

  // Waits a bounded span; an absent answer is a finding when one is due.
  task automatic answer(input bit due, input logic [7:0] st, input int lim);
    int n;
    n = 0;
    while (resp_valid !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk({7'h0, resp_valid}, {7'h0, due});
    if (due) chk(resp_status, st);
  endtask : answer

  task automatic run_frame(input int err_at, input logic [7:0] st);
    got.delete();
    cmd(ppfh_pkg::CMD_WRITE);
    for (int i = 0; i < 40; i++) begin
      byte_valid <= 1'b1;
      byte_data  <= fr[i];
      byte_err   <= (i == err_at);
      do @(posedge sys_clk); while (byte_ready !== 1'b1);
    end
    chk({7'h0, cmd_ready}, 8'h00);
    byte_valid <= 1'b0;
    byte_err   <= 1'b0;
    answer(1'b1, st, 4 * TMO);
    chk(8'(got.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) if (i < got.size()) chk(got[i], exp_q[i]);
  endtask : run_frame

  task automatic sc_plain;
    exp_q.delete();
    for (int i = 0; i < 40; i++) begin
      fr[i] = (i > 30) ? 8'h20 : (i == 5) ? ppfh_pkg::CR_CODE : 8'hc0 + 8'(i);
      exp_q.push_back(fr[i]);
    end
    run_frame(99, ppfh_pkg::ST_OK);
  endtask : sc_plain

  task automatic sc_term;
    delay <= 4'h7;
    foreach (fr[i]) fr[i] = 8'h20;
    fr[0] = 8'h41;
    fr[1] = 8'hc2;
    fr[2] = 8'h43;
    fr[3] = TERM;
    fr[4] = TERM;
    exp_q = '{8'h41, 8'hc2, 8'h43, ppfh_pkg::CR_CODE};
    run_frame(99, ppfh_pkg::ST_OK);
    delay <= 4'h1;
  endtask : sc_term

  task automatic sc_run;
    foreach (fr[i]) fr[i] = 8'h41;
    fr[0] = TERM;
    exp_q = '{ppfh_pkg::BLANK_CODE};
    run_frame(99, ppfh_pkg::ST_OK);
    exp_q = '{ppfh_pkg::CR_CODE};
    run_frame(99, ppfh_pkg::ST_OK);
  endtask : sc_run

  task automatic sc_err;
    exp_q.delete();
    run_frame(5, ppfh_pkg::ST_FRAME_ERR);
    cmd(ppfh_pkg::CMD_STATUS);
    answer(1'b1, ppfh_pkg::ST_FRAME_ERR, 8);
  endtask : sc_err

  task automatic sc_bad;
    cmd(2'h0);
    answer(1'b1, ppfh_pkg::ST_BAD_CMD, 8);
    cmd(2'h3);
    answer(1'b1, ppfh_pkg::ST_BAD_CMD, 8);
  endtask : sc_bad

  task automatic sc_timeout;
    stall <= 1'b1;
    exp_q.delete();
    run_frame(99, ppfh_pkg::ST_TIMEOUT);
    chk({7'h0, prn_strobe}, 8'h00);
    stall <= 1'b0;
  endtask : sc_timeout

  task automatic sc_absent;
    printer_present <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmd(ppfh_pkg::CMD_STATUS);
    answer(1'b0, 8'h00, 20);
    cmd(ppfh_pkg::CMD_WRITE);
    answer(1'b0, 8'h00, 20);
    chk({7'h0, byte_ready}, 8'h00);
    printer_present <= 1'b1;
    printer_power   <= 1'b0;
    repeat (3) @(posedge sys_clk);
    cmd(ppfh_pkg::CMD_STATUS);
    answer(1'b0, 8'h00, 20);
    printer_power <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : sc_absent

  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cmd(ppfh_pkg::CMD_STATUS);
    answer(1'b1, ppfh_pkg::ST_OK, 8);
    sc_bad();
    sc_plain();
    sc_term();
    sc_run();
    sc_err();
    sc_timeout();
    sc_absent();
    sc_plain();
    stop_test();
  end

  // The longest path is the timeout frame; the rest finish well inside this span.
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end
endmodule : tb_top
